// file: common/fcs_regs.vh
// register map, field layout, reset values and mode codes of the clock source block
// Behaviour
// - bus clock is half the source output
// - output divider divides by 1,2,4,8
// - three-bit reference divider for loop reference
// - nine-bit trim value for internal reference
// - debug clock is oscillator output halved
// - reset enters loop-engaged internal mode
// - engaged internal: loop output, internal reference
// - engaged external: loop output, external reference
// - bypassed internal: internal reference out, loop on
// - bypassed internal low power: loop off, no debug
// - bypassed external: external reference out, loop on
// - bypassed external low power: loop off, no debug
// - stop: no clocks, references per configuration
// - external reference up to 5 MHz
// - drive external oscillator control outputs
// - source select 00 loop, 01 internal, 10 external
// - output divider resets to divide by two
// - reference divider resets to one, up to 128
// - low power bit disables loop in bypass unless debug active
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// ***************
// register offsets
// ***************
`define FCS_ADDR_CTRL_ONE 2'h0
`define FCS_ADDR_CTRL_TWO 2'h1
`define FCS_ADDR_TRIM 2'h2
`define FCS_ADDR_STATUS 2'h3

// ***************
// reset values
// ***************
`define FCS_CTRL_ONE_RESET 8'h04
`define FCS_CTRL_TWO_RESET 8'h40
`define FCS_TRIM_RESET 8'h80
`define FCS_FINE_TRIM_RESET 1'h0

// ***************
// control one fields
// ***************
`define FCS_SRC_HI 7
`define FCS_SRC_LO 6
`define FCS_REFDIV_HI 5
`define FCS_REFDIV_LO 3
`define FCS_INT_SEL_BIT 2
`define FCS_INT_EN_BIT 1
`define FCS_INT_STOP_BIT 0

// ***************
// control two fields
// ***************
`define FCS_ODIV_HI 7
`define FCS_ODIV_LO 6
`define FCS_RANGE_BIT 5
`define FCS_GAIN_BIT 4
`define FCS_LOWPWR_BIT 3
`define FCS_EXT_TYPE_BIT 2
`define FCS_EXT_EN_BIT 1
`define FCS_EXT_STOP_BIT 0

// ***************
// source select codes
// ***************
`define FCS_SRC_LOOP 2'h0
`define FCS_SRC_INTERNAL 2'h1
`define FCS_SRC_EXTERNAL 2'h2

// ***************
// operating mode codes
// ***************
`define FCS_MODE_ENG_INT 3'h0
`define FCS_MODE_ENG_EXT 3'h1
`define FCS_MODE_BYP_INT 3'h2
`define FCS_MODE_BYP_INT_LOWPWR 3'h3
`define FCS_MODE_BYP_EXT 3'h4
`define FCS_MODE_BYP_EXT_LOWPWR 3'h5
`define FCS_MODE_STOP 3'h6

// ***************
// timing figures
// ***************
`define FCS_EXT_REF_MAX_KHZ 5000
`define FCS_SYS_CLOCK_KHZ 10000

`endif

// file: design/fcs_tick_divider.v
// power-of-two divider of a tick stream, output registered
`timescale 1ns/10ps
module fcs_tick_divider #(
	parameter SEL_WIDTH = 3,
	parameter CNT_WIDTH = 7
) (
	// clock and reset
	input wire clock,
	input wire resetSync_n,
	// control
	input wire enable,
	input wire [SEL_WIDTH-1:0] divSelect,
	// ticks
	input wire tickIn,
	output reg tickOut
);
	reg [CNT_WIDTH-1:0] count_reg;
	wire [CNT_WIDTH:0] oneWide;
	wire [CNT_WIDTH-1:0] countOne;
	wire [CNT_WIDTH-1:0] lastCount;

	// no zero-width replication, so one-bit counters elaborate
	assign oneWide = {{CNT_WIDTH{1'b0}}, 1'b1};
	assign countOne = oneWide[CNT_WIDTH-1:0];
	// ratio is 2 to the power of the select
	assign lastCount = (countOne << divSelect) - countOne;

	always @(posedge clock or negedge resetSync_n) begin
		if (!resetSync_n) begin
			count_reg <= {CNT_WIDTH{1'b0}};
			tickOut <= 1'b0;
		end else if (!enable) begin
			// disabled divider restarts its phase cleanly
			count_reg <= {CNT_WIDTH{1'b0}};
			tickOut <= 1'b0;
		end else if (tickIn) begin
			if (count_reg >= lastCount) begin
				count_reg <= {CNT_WIDTH{1'b0}};
				tickOut <= 1'b1;
			end else begin
				count_reg <= count_reg + countOne;
				tickOut <= 1'b0;
			end
		end else begin
			tickOut <= 1'b0;
		end
	end
endmodule

// file: design/fcs_clock_source.v
// clock source selection, dividers, mode sequencing and register file
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "fcs_regs.vh"
module fcs_clock_source (
	// clock and reset
	input wire clock,
	input wire reset_n,
	// register port
	input wire [1:0] address,
	input wire [7:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	output reg [7:0] readData,
	// source ticks, one cycle each
	input wire controlledOscTick,
	input wire internalRefTick,
	input wire externalRefTick,
	// system state
	input wire stopRequest,
	input wire backgroundDebugActive,
	// clock outputs as enables
	output reg clockSourceOutTick,
	output reg busClockTick,
	output reg debugClockTick,
	output reg loopRefTick,
	// loop control
	output reg loopEnable,
	output reg loopRefInternal,
	output reg [8:0] trimValue,
	output reg [2:0] operatingMode,
	// reference enables
	output reg internalRefEnable,
	output reg externalRefEnable,
	// external oscillator controls
	output reg oscillatorGainSelect,
	output reg frequencyRangeSelect,
	output reg externalRefTypeSelect,
	output reg externalRefEnableOsc,
	output reg externalRefStopEnable
);
	// ***************
	// reset release
	// ***************
	reg rstMeta_reg;
	reg rstSync_reg;
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	// ***************
	// registers
	// ***************
	reg [7:0] ctrlOne_reg;
	reg [7:0] ctrlTwo_reg;
	reg [7:0] trim_reg;
	reg fineTrim_reg;
	reg [2:0] lastRunMode_reg;
	reg [2:0] mode_next;
	wire [1:0] clockSourceSelect;
	wire [2:0] referenceDividerSelect;
	wire [1:0] outputDividerSelect;
	wire intRefSelect;
	wire bypassLoopDisable;
	wire stopMode;
	wire loopOn;
	wire debugAvailable;

	always @(posedge clock or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			ctrlOne_reg <= `FCS_CTRL_ONE_RESET;
			ctrlTwo_reg <= `FCS_CTRL_TWO_RESET;
			trim_reg <= `FCS_TRIM_RESET;
			fineTrim_reg <= `FCS_FINE_TRIM_RESET;
		end else if (writeStrobe) begin
			case (address)
				`FCS_ADDR_CTRL_ONE: begin
					ctrlOne_reg <= writeData;
				end
				`FCS_ADDR_CTRL_TWO: begin
					ctrlTwo_reg <= writeData;
				end
				`FCS_ADDR_TRIM: begin
					trim_reg <= writeData;
				end
				default: begin
					fineTrim_reg <= writeData[0];
				end
			endcase
		end
	end

	// read data valid in the cycle after the strobe only
	always @(posedge clock or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			readData <= 8'h00;
		end else if (readStrobe) begin
			case (address)
				`FCS_ADDR_CTRL_ONE: begin
					readData <= ctrlOne_reg;
				end
				`FCS_ADDR_CTRL_TWO: begin
					readData <= ctrlTwo_reg;
				end
				`FCS_ADDR_TRIM: begin
					readData <= trim_reg;
				end
				default: begin
					readData <= {4'h0, operatingMode, fineTrim_reg};
				end
			endcase
		end else begin
			readData <= 8'h00;
		end
	end

	assign clockSourceSelect = ctrlOne_reg[`FCS_SRC_HI:`FCS_SRC_LO];
	assign referenceDividerSelect = ctrlOne_reg[`FCS_REFDIV_HI:`FCS_REFDIV_LO];
	assign intRefSelect = ctrlOne_reg[`FCS_INT_SEL_BIT];
	assign outputDividerSelect = ctrlTwo_reg[`FCS_ODIV_HI:`FCS_ODIV_LO];
	assign bypassLoopDisable = ctrlTwo_reg[`FCS_LOWPWR_BIT];

	// ***************
	// mode decode
	// ***************
	// mode from selects, low power and stop
	always @* begin
		mode_next = `FCS_MODE_ENG_INT;
		if (stopRequest) begin
			mode_next = `FCS_MODE_STOP;
		end else begin
			case (clockSourceSelect)
				// low power ignored while debug active
				`FCS_SRC_INTERNAL: begin
					if (bypassLoopDisable && !backgroundDebugActive) begin
						mode_next = `FCS_MODE_BYP_INT_LOWPWR;
					end else begin
						mode_next = `FCS_MODE_BYP_INT;
					end
				end
				`FCS_SRC_EXTERNAL: begin
					if (bypassLoopDisable && !backgroundDebugActive) begin
						mode_next = `FCS_MODE_BYP_EXT_LOWPWR;
					end else begin
						mode_next = `FCS_MODE_BYP_EXT;
					end
				end
				// reserved code behaves as loop select
				default: begin
					if (intRefSelect) begin
						mode_next = `FCS_MODE_ENG_INT;
					end else begin
						mode_next = `FCS_MODE_ENG_EXT;
					end
				end
			endcase
		end
	end

	// low power and stop modes stop the loop
	assign stopMode = (mode_next == `FCS_MODE_STOP);
	assign loopOn = !stopMode && (mode_next != `FCS_MODE_BYP_INT_LOWPWR) &&
		(mode_next != `FCS_MODE_BYP_EXT_LOWPWR);
	// debug clock only while loop runs
	assign debugAvailable = loopOn;

	// ***************
	// reference enables in run and stop
	// ***************
	wire lastInternal;
	wire lastExternal;
	wire intRefEnable_next;
	wire extRefEnable_next;
	assign lastInternal = (lastRunMode_reg == `FCS_MODE_ENG_INT) ||
		(lastRunMode_reg == `FCS_MODE_BYP_INT) || (lastRunMode_reg == `FCS_MODE_BYP_INT_LOWPWR);
	assign lastExternal = (lastRunMode_reg == `FCS_MODE_ENG_EXT) ||
		(lastRunMode_reg == `FCS_MODE_BYP_EXT) || (lastRunMode_reg == `FCS_MODE_BYP_EXT_LOWPWR);
	// stop keeps each reference per its stop enable
	// stop enable kept by software; honoured anyway
	assign intRefEnable_next = stopMode ?
		(ctrlOne_reg[`FCS_INT_STOP_BIT] && (ctrlOne_reg[`FCS_INT_EN_BIT] || lastInternal)) :
		(ctrlOne_reg[`FCS_INT_EN_BIT] || (intRefSelect && loopOn) ||
		(clockSourceSelect == `FCS_SRC_INTERNAL));
	assign extRefEnable_next = stopMode ?
		(ctrlTwo_reg[`FCS_EXT_STOP_BIT] && (ctrlTwo_reg[`FCS_EXT_EN_BIT] || lastExternal)) :
		(ctrlTwo_reg[`FCS_EXT_EN_BIT] || (!intRefSelect && loopOn) ||
		(clockSourceSelect == `FCS_SRC_EXTERNAL));

	// ***************
	// clock selection
	// ***************
	reg selectedTick;
	wire outDivTick;
	wire refDivTick;
	wire busDivTick;
	wire debugDivTick;

	always @* begin
		case (clockSourceSelect)
			`FCS_SRC_INTERNAL: begin
				selectedTick = internalRefTick;
			end
			`FCS_SRC_EXTERNAL: begin
				selectedTick = externalRefTick;
			end
			// engaged modes use the loop output
			default: begin
				selectedTick = controlledOscTick;
			end
		endcase
	end

	// output divider 1, 2, 4 or 8
	fcs_tick_divider #(.SEL_WIDTH(2), .CNT_WIDTH(3)) outputDivider (
		.clock(clock),
		.resetSync_n(rstSync_reg),
		.enable(!stopMode),
		.divSelect(outputDividerSelect),
		.tickIn(selectedTick),
		.tickOut(outDivTick)
	);

	// bus runs at half the source output
	fcs_tick_divider #(.SEL_WIDTH(1), .CNT_WIDTH(1)) busDivider (
		.clock(clock),
		.resetSync_n(rstSync_reg),
		.enable(!stopMode),
		.divSelect(1'b1),
		.tickIn(outDivTick),
		.tickOut(busDivTick)
	);

	// reference from internal or external source
	// reference divided by 1 up to 128
	fcs_tick_divider #(.SEL_WIDTH(3), .CNT_WIDTH(7)) referenceDivider (
		.clock(clock),
		.resetSync_n(rstSync_reg),
		.enable(loopOn),
		.divSelect(referenceDividerSelect),
		.tickIn(intRefSelect ? internalRefTick : externalRefTick),
		.tickOut(refDivTick)
	);

	fcs_tick_divider #(.SEL_WIDTH(1), .CNT_WIDTH(1)) debugDivider (
		.clock(clock),
		.resetSync_n(rstSync_reg),
		.enable(debugAvailable),
		.divSelect(1'b1),
		.tickIn(controlledOscTick),
		.tickOut(debugDivTick)
	);

	// ***************
	// output flops
	// ***************
	always @(posedge clock or negedge rstSync_reg) begin
		if (!rstSync_reg) begin
			clockSourceOutTick <= 1'b0;
			busClockTick <= 1'b0;
			debugClockTick <= 1'b0;
			loopRefTick <= 1'b0;
			loopEnable <= 1'b1;
			loopRefInternal <= 1'b1;
			trimValue <= {`FCS_TRIM_RESET, `FCS_FINE_TRIM_RESET};
			operatingMode <= `FCS_MODE_ENG_INT;
			lastRunMode_reg <= `FCS_MODE_ENG_INT;
			internalRefEnable <= 1'b1;
			externalRefEnable <= 1'b0;
			oscillatorGainSelect <= 1'b0;
			frequencyRangeSelect <= 1'b0;
			externalRefTypeSelect <= 1'b0;
			externalRefEnableOsc <= 1'b0;
			externalRefStopEnable <= 1'b0;
		end else begin
			// no MCU or debug clock in stop
			clockSourceOutTick <= outDivTick && !stopMode;
			busClockTick <= busDivTick && !stopMode;
			debugClockTick <= debugDivTick && debugAvailable;
			loopRefTick <= refDivTick && loopOn;
			loopEnable <= loopOn;
			loopRefInternal <= intRefSelect;
			// nine trim bits, fine bit lowest
			trimValue <= {trim_reg, fineTrim_reg};
			operatingMode <= mode_next;
			if (!stopMode) begin
				lastRunMode_reg <= mode_next;
			end
			// regulator in stop is software's duty
			internalRefEnable <= intRefEnable_next;
			externalRefEnable <= extRefEnable_next;
			oscillatorGainSelect <= ctrlTwo_reg[`FCS_GAIN_BIT];
			frequencyRangeSelect <= ctrlTwo_reg[`FCS_RANGE_BIT];
			externalRefTypeSelect <= ctrlTwo_reg[`FCS_EXT_TYPE_BIT];
			externalRefEnableOsc <= ctrlTwo_reg[`FCS_EXT_EN_BIT];
			externalRefStopEnable <= ctrlTwo_reg[`FCS_EXT_STOP_BIT];
		end
	end
endmodule

// file: tb/fcs_tick_src.sv
// source tick model standing in for oscillator and references
`timescale 1ns/10ps
module fcs_tick_src (
	// clock
	input wire clock,
	// source ticks
	output reg controlledOscTick,
	output reg internalRefTick,
	output reg externalRefTick
);
	// ***************
	// tick phases
	// ***************
	int phase = 0;
	initial begin
		controlledOscTick = 1'h0;
		internalRefTick = 1'h0;
		externalRefTick = 1'h0;
	end
	always @(posedge clock) begin
		phase <= (phase + 1) % 12;
		controlledOscTick <= (phase % 2) == 0;
		internalRefTick <= (phase % 6) == 0;
		externalRefTick <= (phase % 4) == 0;
	end
endmodule

// file: tb/fcs_chk.sv
// port assertions of the clock source block
`timescale 1ns/10ps
module fcs_chk (
	// clock and reset
	input wire clock,
	input wire reset_n,
	// watched ports
	input wire readStrobe,
	input wire [7:0] readData,
	input wire stopRequest,
	input wire backgroundDebugActive,
	input wire clockSourceOutTick,
	input wire busClockTick,
	input wire debugClockTick,
	input wire loopEnable,
	input wire loopRefInternal,
	input wire [8:0] trimValue,
	input wire [2:0] operatingMode
);
	// ***************
	// properties
	// ***************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	busHalf_a: assert property (busClockTick |=> !busClockTick)
		else $error("bus tick in two cycles running");
	debugHalf_a: assert property (debugClockTick |=> !debugClockTick)
		else $error("debug tick in two cycles running");
	resetMode_a: assert property ($rose(reset_n) |->
		(operatingMode == 3'h0 && loopEnable && trimValue == 9'h100)[*3])
		else $error("reset did not settle in engaged internal mode");
	lowPwrNoDebug_a: assert property ((operatingMode == 3'h5)[*4] |-> !debugClockTick)
		else $error("debug tick in external low power mode");
	stopSilent_a: assert property ((operatingMode == 3'h6)[*4] |->
		!clockSourceOutTick && !busClockTick && !debugClockTick && !loopEnable)
		else $error("clock activity in stop mode");
	engagedLoop_a: assert property (operatingMode inside {3'h0, 3'h1, 3'h2, 3'h4} |-> loopEnable)
		else $error("loop off in a mode that keeps it running");
	lowPwrLoopOff_a: assert property ((operatingMode == 3'h3) && !$past(backgroundDebugActive)
		|-> !loopEnable)
		else $error("loop on in low power bypass without debug");
	refSelect_a: assert property (operatingMode == 3'h1 |-> !loopRefInternal)
		else $error("engaged external mode uses internal reference");
	stopEntry_a: assert property (stopRequest |=> operatingMode == 3'h6)
		else $error("stop request not decoded as stop mode");
	readIdle_a: assert property (!$past(readStrobe) |-> readData == 8'h00)
		else $error("read data outside its cycle");
	cover property (operatingMode == 3'h4);
	cover property (operatingMode == 3'h6);
	cover property (operatingMode == 3'h2 && backgroundDebugActive && debugClockTick);
endmodule
bind fcs_clock_source fcs_chk u_chk (.clock, .reset_n, .readStrobe, .readData, .stopRequest,
	.backgroundDebugActive, .clockSourceOutTick, .busClockTick, .debugClockTick, .loopEnable,
	.loopRefInternal, .trimValue, .operatingMode);

// file: tb/fcs_clock_source_tb.sv
// self-checking bench of the clock source block
`timescale 1ns/10ps
module fcs_clock_source_tb;
	// ***************
	// signals
	// ***************
	logic clock, reset_n, writeStrobe, readStrobe, stopRequest, backgroundDebugActive;
	logic [1:0] address;
	logic [7:0] writeData, readData;
	wire controlledOscTick, internalRefTick, externalRefTick;
	logic clockSourceOutTick, busClockTick, debugClockTick, loopRefTick, loopEnable;
	logic loopRefInternal, internalRefEnable, externalRefEnable, oscillatorGainSelect;
	logic frequencyRangeSelect, externalRefTypeSelect, externalRefEnableOsc;
	logic externalRefStopEnable;
	logic [8:0] trimValue, nOut, nBus, nDbg, nRef;
	logic [2:0] operatingMode;
	logic [7:0] c1 [7] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80, 8'hC4};
	logic [7:0] c2 [7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00};
	logic [2:0] md [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
	int per [7] = '{2, 2, 6, 6, 4, 4, 2};
	int bad_count = 0;
	int checks = 0;

	fcs_clock_source u_dut (.clock, .reset_n, .address, .writeData, .writeStrobe, .readStrobe,
		.readData, .controlledOscTick, .internalRefTick, .externalRefTick, .stopRequest,
		.backgroundDebugActive, .clockSourceOutTick, .busClockTick, .debugClockTick,
		.loopRefTick, .loopEnable, .loopRefInternal, .trimValue, .operatingMode,
		.internalRefEnable, .externalRefEnable, .oscillatorGainSelect, .frequencyRangeSelect,
		.externalRefTypeSelect, .externalRefEnableOsc, .externalRefStopEnable);
	fcs_tick_src u_src (.clock, .controlledOscTick, .internalRefTick, .externalRefTick);

	// ***************
	// tasks
	// ***************
	task automatic cmp(input string name, input logic [8:0] exp, input logic [8:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'h1;
		@(posedge clock);
		writeStrobe <= 1'h0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		address <= a;
		readStrobe <= 1'h1;
		@(posedge clock);
		readStrobe <= 1'h0;
		#1;
		cmp("readData", {1'h0, exp}, {1'h0, readData});
	endtask
	// settle first: dividers restart their phase after a mode that disables them
	task automatic measure(input int settle, input int n);
		nOut = 9'h000;
		nBus = 9'h000;
		nDbg = 9'h000;
		nRef = 9'h000;
		repeat (settle) @(posedge clock);
		repeat (n) begin
			@(posedge clock);
			#1;
			nOut += clockSourceOutTick;
			nBus += busClockTick;
			nDbg += debugClockTick;
			nRef += loopRefTick;
		end
	endtask
	task automatic summarize;
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ***************
	// stimulus
	// ***************
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (100000) @(posedge clock);
		bad_count++;
		summarize();
	end
	initial begin
		reset_n = 1'h0;
		address = 2'h0;
		writeData = 8'h00;
		writeStrobe = 1'h0;
		readStrobe = 1'h0;
		stopRequest = 1'h0;
		backgroundDebugActive = 1'h0;
		repeat (10) @(posedge clock);
		reset_n <= 1'h1;
		repeat (3) @(posedge clock);
		rd(2'h0, 8'h04);
		rd(2'h1, 8'h40);
		rd(2'h2, 8'h80);
		rd(2'h3, 8'h00);
		cmp("trimValue", 9'h100, trimValue);
		for (int i = 0; i < 7; i++) begin
			wr(2'h1, c2[i]);
			wr(2'h0, c1[i]);
			measure(40, 480);
			cmp("operatingMode", {6'h00, md[i]}, {6'h00, operatingMode});
			cmp("clockSourceOutTick", 9'(480 / per[i]), nOut);
			cmp("busClockTick", 9'(240 / per[i]), nBus);
			cmp("debugClockTick", (md[i] == 3'h3 || md[i] == 3'h5) ? 9'h000 : 9'h078, nDbg);
		end
		wr(2'h0, 8'h04);
		for (int k = 0; k < 4; k++) begin
			wr(2'h1, 8'(k << 6));
			measure(40, 480);
			cmp("clockSourceOutTick", 9'(240 >> k), nOut);
		end
		wr(2'h1, 8'h40);
		for (int k = 0; k < 8; k++) begin
			wr(2'h0, 8'(4 | (k << 3)));
			measure(800, 1536);
			cmp("loopRefTick", 9'(256 >> k), nRef);
		end
		wr(2'h0, 8'h44);
		wr(2'h1, 8'h08);
		@(posedge clock);
		backgroundDebugActive <= 1'h1;
		measure(40, 480);
		cmp("debugClockTick", 9'h078, nDbg);
		cmp("refEnables", 9'h002, {7'h00, internalRefEnable, externalRefEnable});
		@(posedge clock);
		backgroundDebugActive <= 1'h0;
		stopRequest <= 1'h1;
		measure(40, 480);
		cmp("operatingMode", 9'h006, {6'h00, operatingMode});
		cmp("clockSourceOutTick", 9'h000, nOut + nDbg);
		cmp("refEnables", 9'h000, {7'h00, internalRefEnable, externalRefEnable});
		@(posedge clock);
		stopRequest <= 1'h0;
		wr(2'h2, 8'h5A);
		wr(2'h3, 8'hFF);
		@(posedge clock);
		#1;
		cmp("trimValue", 9'h0B5, trimValue);
		rd(2'h3, 8'h07);
		// external kept in stop after bypass
		wr(2'h1, 8'h01);
		wr(2'h0, 8'h80);
		@(posedge clock);
		stopRequest <= 1'h1;
		repeat (3) @(posedge clock);
		#1;
		cmp("refEnables", 9'h001, {7'h00, internalRefEnable, externalRefEnable});
		@(posedge clock);
		stopRequest <= 1'h0;
		foreach (per[j]) begin
			wr(2'h1, (j % 2) ? 8'h25 : 8'h1A);
			repeat (2) @(posedge clock);
			#1;
			cmp("oscControls", (j % 2) ? 9'h015 : 9'h00A, {4'h0, frequencyRangeSelect,
				oscillatorGainSelect, externalRefTypeSelect, externalRefEnableOsc,
				externalRefStopEnable});
		end
		summarize();
	end
endmodule
